// ### verilog/timer_counter_pwm16.sv
// Notes on behaviour
// - sixteen-bit counter, counts down only
// - compare output uses selectable relation
// - period loads on start, reset, terminal count except in one-shot
// - interrupt on tc, compare or capture
// - capture input stores full current count
// - gated mode decrements only while enabled
// - one-shot stops at end of period
// - free-run reloads and continues forever
// - complementary pwm pair with deadband
// - kill forces pwm outputs inactive
// - tc output may carry inverted compare
// - counting clock chosen from several sources
`timescale 1ns/1ns
`include "timer_map.svh"

module timer_counter_pwm16 #(
  parameter int CNT_W = 16,
  parameter int DB_W  = 8
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // routed control inputs
  input  wire logic        i_enable,
  input  wire logic        i_tmr_reset,
  input  wire logic        i_capture,
  input  wire logic        i_kill,
  input  wire logic        i_ext_clk0,
  input  wire logic        i_ext_clk1,
  // routed outputs
  output logic             o_cmp,
  output logic             o_tc,
  output logic             o_pwm_hi,
  output logic             o_pwm_lo,
  output logic             o_irq
);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  timer_pkg::ctrl_type  ctrl_reg;
  timer_pkg::state_type state_reg;
  timer_pkg::state_type state_next;
  timer_pkg::event_type evt;
  logic [CNT_W-1:0]     period_reg;
  logic [CNT_W-1:0]     compare_reg;
  logic [CNT_W-1:0]     capture_reg;
  logic [CNT_W-1:0]     count_reg;
  logic [CNT_W-1:0]     count_next;
  logic [DB_W-1:0]      dead_reg;
  logic [15:0]          clkdiv_reg;
  logic                 start_prev_reg;
  logic                 cap_prev_reg;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic        setup_ph;
  logic        wr_done;
  logic        read_ph;
  logic        sel_ctrl;
  logic        sel_period;
  logic        sel_compare;
  logic        sel_capture;
  logic        sel_count;
  logic        sel_status;
  logic        sel_dead;
  logic        sel_clkdiv;
  logic        mapped;
  logic [31:0] rdata_mux;

  // no wait state: pready rises the cycle after setup
  // pslverr flags unmapped offsets; writes to read-only places drop silently
  assign setup_ph    = i_psel & ~i_penable;
  assign read_ph     = setup_ph & ~i_pwrite;
  assign wr_done     = i_psel & i_penable & o_pready & i_pwrite;
  assign sel_ctrl    = (i_paddr == `TMR_CTRL_OFS);
  assign sel_period  = (i_paddr == `TMR_PERIOD_OFS);
  assign sel_compare = (i_paddr == `TMR_COMPARE_OFS);
  assign sel_capture = (i_paddr == `TMR_CAPTURE_OFS);
  assign sel_count   = (i_paddr == `TMR_COUNT_OFS);
  assign sel_status  = (i_paddr == `TMR_STATUS_OFS);
  assign sel_dead    = (i_paddr == `TMR_DEADBAND_OFS);
  assign sel_clkdiv  = (i_paddr == `TMR_CLKDIV_OFS);
  assign mapped      = sel_ctrl | sel_period | sel_compare | sel_capture
                     | sel_count | sel_status | sel_dead | sel_clkdiv;

  // ----------------------------------------
  // counting enable
  // ----------------------------------------
  logic tick;
  logic count_ok;
  logic running;
  logic start_rise;
  logic cmp_true;
  logic tc_hit;

  // source selection and divider
  clk_src_sel #(
    .DIV_W (16)
  ) u_clk_src (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_sel    (ctrl_reg.clk_sel),
    .i_div    (clkdiv_reg),
    .i_ext0   (i_ext_clk0),
    .i_ext1   (i_ext_clk1),
    .o_tick   (tick)
  );

  // gated mode counts only while the enable input is high
  assign count_ok = tick & ((ctrl_reg.mode != timer_pkg::MODE_GATED)
                  | i_enable);
  assign running    = (state_reg == timer_pkg::ST_RUN);
  assign start_rise = ctrl_reg.start & ~start_prev_reg;
  assign tc_hit     = running & count_ok & (count_reg == '0);

  // ----------------------------------------
  // run state
  // ----------------------------------------
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      timer_pkg::ST_IDLE:
        if (start_rise)
          state_next = timer_pkg::ST_RUN;
      timer_pkg::ST_RUN:
        if (!ctrl_reg.start)
          state_next = timer_pkg::ST_IDLE;
        else if (tc_hit && ctrl_reg.mode == timer_pkg::MODE_ONESHOT)
          state_next = timer_pkg::ST_DONE;
      timer_pkg::ST_DONE:
        if (!ctrl_reg.start)
          state_next = timer_pkg::ST_IDLE;
        else if (i_tmr_reset)
          state_next = timer_pkg::ST_RUN;
    endcase
  end

  // ----------------------------------------
  // counter
  // ----------------------------------------
  // reload has priority; a one-shot holds zero once finished
  // a start write while already running keeps the period going; firmware
  // must clear start first to restart from a fresh reload
  always_comb
  begin
    count_next = count_reg;
    if (start_rise || i_tmr_reset)
      count_next = period_reg;
    else if (tc_hit && ctrl_reg.mode != timer_pkg::MODE_ONESHOT)
      count_next = period_reg;
    else if (running && count_ok && count_reg != '0)
      count_next = count_reg - 1'b1;
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state_reg      <= timer_pkg::ST_IDLE;
      count_reg      <= '0;
      start_prev_reg <= 1'b0;
    end
    else
    begin
      state_reg      <= state_next;
      count_reg      <= count_next;
      start_prev_reg <= ctrl_reg.start;
    end
  end

  // ----------------------------------------
  // compare and capture
  // ----------------------------------------
  // unused relation codes never match
  always_comb
  begin
    unique case (ctrl_reg.rel)
      timer_pkg::REL_LT:  cmp_true = count_reg <  compare_reg;
      timer_pkg::REL_LTE: cmp_true = count_reg <= compare_reg;
      timer_pkg::REL_EQ:  cmp_true = count_reg == compare_reg;
      timer_pkg::REL_GTE: cmp_true = count_reg >= compare_reg;
      timer_pkg::REL_GT:  cmp_true = count_reg >  compare_reg;
      default:            cmp_true = 1'b0;
    endcase
  end

  assign evt.tc  = tc_hit;
  assign evt.cmp = running & cmp_true;
  assign evt.cap = i_capture & ~cap_prev_reg;

  // capture takes the count as it stands before this edge
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      capture_reg  <= '0;
      cap_prev_reg <= 1'b0;
    end
    else
    begin
      cap_prev_reg <= i_capture;
      if (evt.cap)
        capture_reg <= count_reg;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  logic db_hi;
  logic db_lo;
  logic cmp_gated;
  logic tc_level;
  logic pwm_hi_gated;
  logic pwm_lo_gated;
  logic irq_any;

  // complementary pair from the compare level; it takes the unkilled level
  // so a kill pulse does not restart the dead time
  deadband_gen #(
    .DB_W (DB_W)
  ) u_deadband (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_pwm    (evt.cmp),
    .i_dead   (dead_reg),
    .o_hi     (db_hi),
    .o_lo     (db_lo)
  );

  // kill acts after the deadband so it takes hold in one cycle
  assign cmp_gated    = evt.cmp & ~i_kill;
  assign tc_level     = ctrl_reg.tc_is_ncmp ? ~cmp_gated : evt.tc;
  assign pwm_hi_gated = db_hi & ~i_kill;
  assign pwm_lo_gated = db_lo & ~i_kill;
  // a compare interrupt is a level for as long as the match holds
  assign irq_any      = |(ctrl_reg.irq_en & evt);

  // output flops
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_cmp    <= 1'b0;
      o_tc     <= 1'b0;
      o_pwm_hi <= 1'b0;
      o_pwm_lo <= 1'b0;
      o_irq    <= 1'b0;
    end
    else
    begin
      o_cmp    <= cmp_gated;
      o_tc     <= tc_level;
      o_pwm_hi <= pwm_hi_gated;
      o_pwm_lo <= pwm_lo_gated;
      o_irq    <= irq_any;
    end
  end

  // ----------------------------------------
  // register file
  // ----------------------------------------
  // the count read path only samples, never writes back
  always_comb
  begin
    rdata_mux = 32'h0000_0000;
    if (sel_ctrl)
      rdata_mux[`CTRL_WIDTH-1:0] = ctrl_reg;
    if (sel_period)
      rdata_mux[CNT_W-1:0] = period_reg;
    if (sel_compare)
      rdata_mux[CNT_W-1:0] = compare_reg;
    if (sel_capture)
      rdata_mux[CNT_W-1:0] = capture_reg;
    if (sel_count)
      rdata_mux[CNT_W-1:0] = count_reg;
    if (sel_status)
      rdata_mux[5:0] = {state_reg, evt};
    if (sel_dead)
      rdata_mux[DB_W-1:0] = dead_reg;
    if (sel_clkdiv)
      rdata_mux[15:0] = clkdiv_reg;
  end

  // apb answer path
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
    end
    else
    begin
      o_pready  <= setup_ph;
      o_pslverr <= setup_ph & ~mapped;
      o_prdata  <= read_ph ? rdata_mux : 32'h0000_0000;
    end
  end

  // writable registers; unmapped writes are dropped
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      ctrl_reg    <= `CTRL_RST;
      period_reg  <= `PERIOD_RST;
      compare_reg <= `COMPARE_RST;
      dead_reg    <= `DEADBAND_RST;
      clkdiv_reg  <= `CLKDIV_RST;
    end
    else if (wr_done)
    begin
      if (sel_ctrl)
        ctrl_reg <= timer_pkg::ctrl_type'(i_pwdata[`CTRL_WIDTH-1:0]);
      if (sel_period)
        period_reg <= i_pwdata[CNT_W-1:0];
      if (sel_compare)
        compare_reg <= i_pwdata[CNT_W-1:0];
      if (sel_dead)
        dead_reg <= i_pwdata[DB_W-1:0];
      if (sel_clkdiv)
        clkdiv_reg <= i_pwdata[15:0];
    end
  end

endmodule

// ### verilog/timer_map.svh
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define TMR_CTRL_OFS      12'h000
`define TMR_PERIOD_OFS    12'h004
`define TMR_COMPARE_OFS   12'h008
`define TMR_CAPTURE_OFS   12'h00c
`define TMR_COUNT_OFS     12'h010
`define TMR_STATUS_OFS    12'h014
`define TMR_DEADBAND_OFS  12'h018
`define TMR_CLKDIV_OFS    12'h01c

// ----------------------------------------
// control register field positions
// ----------------------------------------
`define CTRL_START_BIT    0
`define CTRL_MODE_LSB     1
`define CTRL_REL_LSB      3
`define CTRL_TCSEL_BIT    6
`define CTRL_IRQEN_LSB    7
`define CTRL_CLKSEL_LSB   10
`define CTRL_WIDTH        12

// ----------------------------------------
// reset values
// ----------------------------------------
`define CTRL_RST          12'h000
`define PERIOD_RST        16'hffff
`define COMPARE_RST       16'h8000
`define DEADBAND_RST      8'h00
`define CLKDIV_RST        16'h0000

`endif

// ### verilog/timer_pkg.sv
package timer_pkg;

  // counting modes
  typedef enum logic [1:0] {
    MODE_FREE    = 2'h0,
    MODE_ONESHOT = 2'h1,
    MODE_GATED   = 2'h2
  } mode_type;

  // compare relations between count and compare value
  typedef enum logic [2:0] {
    REL_LT  = 3'h0,
    REL_LTE = 3'h1,
    REL_EQ  = 3'h2,
    REL_GTE = 3'h3,
    REL_GT  = 3'h4
  } rel_type;

  // counting clock sources
  typedef enum logic [1:0] {
    SRC_SYS  = 2'h0,
    SRC_DIV  = 2'h1,
    SRC_EXT0 = 2'h2,
    SRC_EXT1 = 2'h3
  } clk_src_type;

  // counter run state, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN  = 3'b010,
    ST_DONE = 3'b100
  } state_type;

  // control register layout
  typedef struct packed {
    clk_src_type clk_sel;
    logic [2:0]  irq_en;    // {capture, compare, terminal count}
    logic        tc_is_ncmp;
    rel_type     rel;
    mode_type    mode;
    logic        start;
  } ctrl_type;

  // block events
  typedef struct packed {
    logic cap;
    logic cmp;
    logic tc;
  } event_type;

endpackage

// ### verilog/clk_src_sel.sv
`timescale 1ns/1ns
`include "timer_map.svh"

module clk_src_sel #(
  parameter int DIV_W = 16
) (
  // clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_arst_n,
  // selection
  input  wire timer_pkg::clk_src_type i_sel,
  input  wire logic [DIV_W-1:0]     i_div,
  // routed clock sources, synchronous to i_clk
  input  wire logic                 i_ext0,
  input  wire logic                 i_ext1,
  // one-cycle counting enable
  output logic                      o_tick
);

  logic [DIV_W-1:0] div_reg;
  logic             ext0_reg;
  logic             ext1_reg;
  logic             div_wrap;
  logic             tick_next;

  // divider wraps after i_div + 1 cycles
  assign div_wrap = (div_reg >= i_div);

  // the routed sources count on their rising edge only
  always_comb
  begin
    unique case (i_sel)
      timer_pkg::SRC_SYS:  tick_next = 1'b1;
      timer_pkg::SRC_DIV:  tick_next = div_wrap;
      timer_pkg::SRC_EXT0: tick_next = i_ext0 & ~ext0_reg;
      timer_pkg::SRC_EXT1: tick_next = i_ext1 & ~ext1_reg;
    endcase
  end

  // divider and edge history
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      div_reg  <= '0;
      ext0_reg <= 1'b0;
      ext1_reg <= 1'b0;
      o_tick   <= 1'b0;
    end
    else
    begin
      div_reg  <= div_wrap ? '0 : div_reg + 1'b1;
      ext0_reg <= i_ext0;
      ext1_reg <= i_ext1;
      o_tick   <= tick_next;
    end
  end

endmodule

// ### verilog/deadband_gen.sv
`timescale 1ns/1ns

module deadband_gen #(
  parameter int DB_W = 8
) (
  // clock and reset
  input  wire logic            i_clk,
  input  wire logic            i_arst_n,
  // pwm level and dead time in clock cycles
  input  wire logic            i_pwm,
  input  wire logic [DB_W-1:0] i_dead,
  // complementary pair
  output logic                 o_hi,
  output logic                 o_lo
);

  logic            prev_reg;
  logic [DB_W-1:0] cnt_reg;
  logic            edge_seen;

  assign edge_seen = (i_pwm != prev_reg);

  // on each transition both sides go inactive for the dead time plus one cycle,
  // so the pair never overlaps even with a zero setting
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      prev_reg <= 1'b0;
      cnt_reg  <= '0;
      o_hi     <= 1'b0;
      o_lo     <= 1'b0;
    end
    else if (edge_seen)
    begin
      prev_reg <= i_pwm;
      cnt_reg  <= i_dead;
      o_hi     <= 1'b0;
      o_lo     <= 1'b0;
    end
    else if (cnt_reg != '0)
      cnt_reg <= cnt_reg - 1'b1;
    else
    begin
      o_hi <= prev_reg;
      o_lo <= ~prev_reg;
    end
  end

endmodule

// ### dv/routed_src.sv
`timescale 1ns/1ns

// ----------------------------------------
// routed count sources beside the timer
// ----------------------------------------
module routed_src (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  // count sources toward the timer
  output logic      o_ext0,
  output logic      o_ext1
);
  logic [1:0] ph0_reg;
  logic [1:0] ph1_reg;

  // distinct rates (4 and 3 clocks) so a wrong source pick shows up
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      ph0_reg <= 2'h0;
      ph1_reg <= 2'h0;
    end
    else
    begin
      ph0_reg <= ph0_reg + 2'h1;
      ph1_reg <= (ph1_reg == 2'h2) ? 2'h0 : ph1_reg + 2'h1;
    end
  end

  assign o_ext0 = ph0_reg[1];
  assign o_ext1 = (ph1_reg == 2'h2);
endmodule

// ### dv/timer_counter_pwm16_props.sv
`timescale 1ns/1ns

module timer_counter_pwm16_props (
  // clock and reset
  input wire logic        i_clk,
  input wire logic        i_arst_n,
  // bus
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  // routed signals
  input wire logic        i_kill,
  input wire logic        o_cmp,
  input wire logic        o_tc,
  input wire logic        o_pwm_hi,
  input wire logic        o_pwm_lo,
  input wire logic        o_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  // bus answers one cycle after setup, for one cycle
  a_ready_setup: assert property (i_psel && !i_penable |=> o_pready)
    else $error("no ready after setup");
  a_ready_single: assert property (o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  a_err_ready: assert property (o_pslverr |-> o_pready)
    else $error("error without ready");
  a_rdata_idle: assert property (!o_pready |-> o_prdata == 32'h0)
    else $error("read data outside access");
  // kill acts at the output flops
  a_kill_cmp: assert property (i_kill |=> !o_cmp)
    else $error("compare active under kill");
  a_kill_pwm: assert property (i_kill |=> !o_pwm_hi && !o_pwm_lo)
    else $error("pwm active under kill");
  // both sides never high together, and a gap precedes each rise
  a_pwm_excl: assert property (!(o_pwm_hi && o_pwm_lo))
    else $error("both pwm sides high");
  a_gap_lo: assert property ($rose(o_pwm_lo) |-> !$past(o_pwm_hi))
    else $error("low side rose without dead time");
  a_gap_hi: assert property ($rose(o_pwm_hi) |-> !$past(o_pwm_lo))
    else $error("high side rose without dead time");

  c_tc: cover property (o_tc);
  c_irq: cover property (o_irq);
  c_pwm: cover property ($rose(o_pwm_lo));
  c_err: cover property (o_pslverr);
endmodule

bind timer_counter_pwm16 timer_counter_pwm16_props timer_counter_pwm16_props_inst (
  .i_clk(i_clk), .i_arst_n(i_arst_n), .i_psel(i_psel), .i_penable(i_penable),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_kill(i_kill),
  .o_cmp(o_cmp), .o_tc(o_tc), .o_pwm_hi(o_pwm_hi), .o_pwm_lo(o_pwm_lo), .o_irq(o_irq)
);

// ### dv/timer_counter_pwm16_tb_top.sv
`timescale 1ns/1ns
`include "timer_map.svh"

module timer_counter_pwm16_tb_top;
  logic        clk, rst_n, psel, pen, pwr, en, trst, cap, kill;
  logic        e0, e1, rdy, err, cmp, tc, hi, lo, irq, err_s;
  logic [11:0] addr;
  logic [31:0] wd, prd, q;
  int          fail_count, checked, k, n;
  // watched levels for the bounded waits, one bit each
  logic [4:0]  mon;
  localparam int rdy_b = 0;
  localparam int tc_b  = 1;
  localparam int irq_b = 2;
  localparam int hi_b  = 3;
  localparam int lo_b  = 4;

  assign mon = {lo, hi, irq, tc, rdy};

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  timer_counter_pwm16 timer_counter_pwm16_inst (
    .i_clk(clk), .i_arst_n(rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(addr), .i_pwdata(wd), .o_prdata(prd), .o_pready(rdy), .o_pslverr(err),
    .i_enable(en), .i_tmr_reset(trst), .i_capture(cap), .i_kill(kill),
    .i_ext_clk0(e0), .i_ext_clk1(e1), .o_cmp(cmp), .o_tc(tc), .o_pwm_hi(hi),
    .o_pwm_lo(lo), .o_irq(irq)
  );

  routed_src routed_src_inst (.i_clk(clk), .i_arst_n(rst_n), .o_ext0(e0), .o_ext1(e1));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // bounded wait for a level, looked at mid-cycle where it has settled,
  // so the matching rising edge is the next one; k counts the cycles taken
  task automatic wait_lv(input int b, input logic v);
    k = 0;
    do
    begin
      @(negedge clk);
      k++;
    end
    while (mon[b] !== v && k < 300);
    if (mon[b] !== v)
    begin
      fail_count++;
      end_sim;
    end
  endtask

  // one transfer: setup, then held access until ready is sampled
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr  <= w;
    addr <= a;
    wd   <= d;
    @(posedge clk);
    pen <= 1'b1;
    wait_lv(rdy_b, 1'b1);
    q     = prd;
    err_s = err;
    @(posedge clk);
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  function automatic logic [31:0] mk(input logic [1:0] m, input logic [2:0] r,
                                     input logic nc, input logic [2:0] ie,
                                     input logic [1:0] s);
    return {20'h0, s, ie, nc, r, m, 1'b1};
  endfunction

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    logic [11:0] a[7] = '{`TMR_CTRL_OFS, `TMR_PERIOD_OFS, `TMR_COMPARE_OFS,
      `TMR_CAPTURE_OFS, `TMR_COUNT_OFS, `TMR_DEADBAND_OFS, `TMR_CLKDIV_OFS};
    logic [31:0] e[7] = '{32'h0, 32'hffff, 32'h8000, 32'h0, 32'h0, 32'h0, 32'h0};
    for (int i = 0; i < 7; i++)
    begin
      apb(1'b0, a[i], 32'h0);
      check(q, e[i]);
    end
    // unmapped place is refused and stays empty
    apb(1'b1, 12'h020, 32'h5a5a);
    check(err_s, 1'b1);
    apb(1'b0, 12'h020, 32'h0);
    check(q, 32'h0);
    check(err_s, 1'b1);
    $display("done: register defaults");
  endtask

  // tc spacing for each count source, period 2 gives 3 ticks per turn
  task automatic t_src;
    int g[4] = '{3, 6, 12, 9};
    apb(1'b1, `TMR_PERIOD_OFS, 32'h2);
    apb(1'b1, `TMR_CLKDIV_OFS, 32'h1);
    for (int s = 0; s < 4; s++)
    begin
      apb(1'b1, `TMR_CTRL_OFS, mk(2'h0, 3'h0, 1'b0, 3'h1, s[1:0]));
      wait_lv(tc_b, 1'b1);
      wait_lv(tc_b, 1'b0);
      wait_lv(tc_b, 1'b1);
      wait_lv(tc_b, 1'b1);
      check(k, g[s]);
    end
    $display("done: count sources");
  endtask

  task automatic t_oneshot;
    apb(1'b1, `TMR_CTRL_OFS, 32'h0);
    apb(1'b1, `TMR_PERIOD_OFS, 32'h3);
    apb(1'b1, `TMR_CTRL_OFS, mk(2'h1, 3'h0, 1'b0, 3'h0, 2'h0));
    n = 0;
    repeat (40)
    begin
      @(negedge clk);
      n += tc;
    end
    check(n, 1);
    apb(1'b0, `TMR_STATUS_OFS, 32'h0);
    check(q[5:3], 3'b100);
    $display("done: one shot");
  endtask

  task automatic t_gated;
    apb(1'b1, `TMR_CTRL_OFS, 32'h0);
    apb(1'b1, `TMR_PERIOD_OFS, 32'h64);
    apb(1'b1, `TMR_CTRL_OFS, mk(2'h2, 3'h0, 1'b0, 3'h4, 2'h0));
    repeat (5) @(posedge clk);
    apb(1'b0, `TMR_COUNT_OFS, 32'h0);
    check(q, 32'h64);
    en <= 1'b1;
    repeat (10) @(posedge clk);
    en <= 1'b0;
    apb(1'b0, `TMR_COUNT_OFS, 32'h0);
    check(q, 32'h5a);
    cap <= 1'b1;
    wait_lv(irq_b, 1'b1);
    check(k, 2);
    @(posedge clk);
    cap  <= 1'b0;
    apb(1'b0, `TMR_CAPTURE_OFS, 32'h0);
    check(q, 32'h5a);
    trst <= 1'b1;
    @(posedge clk);
    trst <= 1'b0;
    apb(1'b0, `TMR_COUNT_OFS, 32'h0);
    check(q, 32'h64);
    $display("done: gated count");
  endtask

  // count held at 100 against compare 100: LT LTE EQ GTE GT
  task automatic t_rel;
    logic [4:0] ex = 5'b01110;
    apb(1'b1, `TMR_COMPARE_OFS, 32'h64);
    for (int r = 0; r < 5; r++)
    begin
      apb(1'b1, `TMR_CTRL_OFS, mk(2'h2, r[2:0], 1'b1, 3'h2, 2'h0));
      repeat (3) @(negedge clk);
      check({cmp, tc, irq}, {ex[r], ~ex[r], ex[r]});
    end
    // kill while the high side is on, so cmp and the high side have to fall and tc has to rise
    apb(1'b1, `TMR_CTRL_OFS, mk(2'h2, 3'h3, 1'b1, 3'h0, 2'h0));
    repeat (4) @(negedge clk);
    check({cmp, hi, lo, tc}, 4'hc);
    @(posedge clk);
    kill <= 1'b1;
    repeat (2) @(negedge clk);
    check({cmp, hi, lo, tc}, 4'h1);
    @(posedge clk);
    kill <= 1'b0;
    $display("done: compare relations");
  endtask

  task automatic t_dead;
    apb(1'b1, `TMR_PERIOD_OFS, 32'h9);
    apb(1'b1, `TMR_COMPARE_OFS, 32'h5);
    apb(1'b1, `TMR_DEADBAND_OFS, 32'h2);
    apb(1'b1, `TMR_CTRL_OFS, mk(2'h0, 3'h0, 1'b0, 3'h0, 2'h0));
    wait_lv(hi_b, 1'b1);
    wait_lv(hi_b, 1'b0);
    wait_lv(lo_b, 1'b1);
    check(k, 3);
    $display("done: dead time");
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    {psel, pen, pwr, en, trst, cap, kill} = 7'h0;
    addr       = 12'h0;
    wd         = 32'h0;
    rst_n      = 1'b0;
    fail_count = 0;
    checked    = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_src;
    t_oneshot;
    t_gated;
    t_rel;
    t_dead;
    end_sim;
  end
endmodule
